// >>> shared/bbcr_cfg.svh
// offsets, field positions, reset values and timing counts of the buck registers
`ifndef BBCR_CFG_SVH
`define BBCR_CFG_SVH

`define BBCR_ADDR_W 8
`define BBCR_DATA_W 8

`define BBCR_OFS_A_CTRL 8'h35
`define BBCR_OFS_A_LIMIT 8'h36
`define BBCR_OFS_B_RUN 8'h38
`define BBCR_OFS_B_STBY 8'h39
`define BBCR_OFS_B_SLP 8'h3a
`define BBCR_OFS_B_CTRL 8'h3b

`define BBCR_A_ILIM_HI 1
`define BBCR_A_ILIM_LO 0
`define BBCR_A_TMODE_BIT 4
`define BBCR_A_SLEEP_BIT 2
`define BBCR_CODE_HI 5
`define BBCR_CODE_LO 0

`define BBCR_B_RUN_EN_BIT 0
`define BBCR_B_STBY_EN_BIT 1
`define BBCR_B_SLEEP_EN_BIT 2
`define BBCR_B_LPWR_BIT 3
`define BBCR_B_SLEW_BIT 4
`define BBCR_B_DESC_FORCE_BIT 5
`define BBCR_B_FORCE_BIT 6
`define BBCR_B_DIS_OFF_BIT 7

`define BBCR_RST_ILIM 2'h0
`define BBCR_RST_CODE 6'h00
`define BBCR_RST_CTRL 8'h00
`define BBCR_RST_BYTE 8'h00
`define BBCR_LOAD_CYCLES 2'h2

`define BBCR_CLK_PERIOD_NS 10
`define BBCR_STEP_FAST_NS 2000
`define BBCR_STEP_SLOW_NS 4000
`define BBCR_STEP_FAST_CYC (`BBCR_STEP_FAST_NS / `BBCR_CLK_PERIOD_NS)
`define BBCR_STEP_SLOW_CYC (`BBCR_STEP_SLOW_NS / `BBCR_CLK_PERIOD_NS)
`define BBCR_TICK_W 9

`endif

// >>> shared/bbcr_pkg.sv
// types of the buck regulator control register bank
package bbcr_pkg;

  typedef enum logic [1:0] {
    BBCR_MODE_RUN = 2'b00,
    BBCR_MODE_STANDBY = 2'b01,
    BBCR_MODE_SLEEP = 2'b10,
    BBCR_MODE_OFF = 2'b11
  } bbcr_mode_type;

  typedef enum logic {
    BBCR_PH_LOAD = 1'b0,
    BBCR_PH_RUN = 1'b1
  } bbcr_phase_type;

  typedef struct packed {
    logic [1:0] a_ilim;
    logic [5:0] b_run_code;
    logic b_run_enable;
    logic b_scaling_slew;
    logic b_discharge_disable;
    logic scaling_select;
  } bbcr_fuse_type;

  typedef struct packed {
    bbcr_fuse_type fuse;
    logic [1:0] mode;
    logic a_sleep_set;
  } bbcr_sync_type;

  typedef struct packed {
    logic [1:0] a_current_limit;
    logic a_timing_scheme;
    logic a_sleep_enable;
    logic b_on;
    logic [5:0] b_code;
    logic b_low_power;
    logic b_slew_slow;
    logic b_step_tick;
    logic b_forced_conduction_on_descent;
    logic b_forced_conduction;
    logic b_discharge_on;
  } bbcr_drive_type;

  typedef struct packed {
    bbcr_sync_type sync1;
    bbcr_sync_type sync2;
    bbcr_phase_type phase;
    logic [1:0] load_cnt;
    logic [1:0] a_ilim;
    logic a_tmode;
    logic a_sleep_en;
    logic [5:0] b_run;
    logic [5:0] b_stby;
    logic [5:0] b_slp;
    logic [7:0] b_ctrl;
    logic [7:0] rdata;
    logic [8:0] tick_cnt;
    bbcr_drive_type drive;
  } bbcr_state_type;

endpackage

// >>> logic/bbcr_regs.sv
// buck converter control register bank with fuse load and mode decode
// Summary of operation
// - two-bit field selects first converter current limit 1.0/1.2/1.5/2.0 A
// - bit 4 of first converter limit register: 0 on-time, 1 off-time
// - six-bit run voltage code of second converter in bits 5 to 0
// - six-bit standby code, defaulting to the run code
// - six-bit sleep code, defaulting to the run code
// - control bit 0 run enable, fuse loaded, writing 0 turns it off
// - control bit 1 standby enable, defaulting to the fuse run enable
// - control bit 2 sleep enable, 0 turns converter off in sleep
// - control bit 3 puts converter in low power during standby or sleep
// - control bit 4 slew: 0 step every 2 us, 1 every 4 us
// - slew bit ignored while fuse scaling select is 1
// - control bit 5 forces continuous conduction during downward scaling
// - control bit 6 forces pulse width continuous conduction always
// - control bit 7 at 0 connects discharge resistor while disabled
// - fuse loaded fields take fuse values after reset, stay read/write
// - first converter sleep enable set by a request through a two-stage synchronizer, host read/write
`include "bbcr_cfg.svh"

module bbcr_regs (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [`BBCR_ADDR_W-1:0] reg_addr,
  input wire logic [`BBCR_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`BBCR_DATA_W-1:0] reg_rdata,
  input wire bbcr_pkg::bbcr_fuse_type fuse_in,
  input wire logic [1:0] power_mode,
  input wire logic buck_a_sleep_set,
  output bbcr_pkg::bbcr_drive_type buck_drive
);

  bbcr_pkg::bbcr_state_type st_r;
  bbcr_pkg::bbcr_state_type st_nxt;

  assign reg_rdata = st_r.rdata;
  assign buck_drive = st_r.drive;

  always_comb
  begin
    logic wr;
    logic rd;
    logic on;
    logic slow;
    logic [8:0] limit;
    wr = 1'b0;
    rd = 1'b0;
    on = 1'b0;
    slow = 1'b0;
    limit = 9'h000;
    st_nxt = st_r;
    // fuses, mode and set request come from other domains
    st_nxt.sync1.fuse = fuse_in;
    st_nxt.sync1.mode = power_mode;
    st_nxt.sync1.a_sleep_set = buck_a_sleep_set;
    st_nxt.sync2 = st_r.sync1;

    // host writes before the fuse load would be overwritten, so drop them; reads pass
    wr = reg_write && (st_r.phase == bbcr_pkg::BBCR_PH_RUN);
    rd = reg_read;

    case (st_r.phase)
      bbcr_pkg::BBCR_PH_LOAD:
      begin
        if (st_r.load_cnt == `BBCR_LOAD_CYCLES)
        begin
          st_nxt.a_ilim = st_r.sync2.fuse.a_ilim;
          st_nxt.b_run = st_r.sync2.fuse.b_run_code;
          st_nxt.b_stby = st_r.sync2.fuse.b_run_code;
          st_nxt.b_slp = st_r.sync2.fuse.b_run_code;
          st_nxt.b_ctrl[`BBCR_B_RUN_EN_BIT] =
            st_r.sync2.fuse.b_run_enable;
          st_nxt.b_ctrl[`BBCR_B_STBY_EN_BIT] =
            st_r.sync2.fuse.b_run_enable;
          st_nxt.b_ctrl[`BBCR_B_SLEW_BIT] =
            st_r.sync2.fuse.b_scaling_slew;
          st_nxt.b_ctrl[`BBCR_B_DIS_OFF_BIT] =
            st_r.sync2.fuse.b_discharge_disable;
          st_nxt.phase = bbcr_pkg::BBCR_PH_RUN;
        end
        else
        begin
          st_nxt.load_cnt = st_r.load_cnt + 2'h1;
        end
      end
      bbcr_pkg::BBCR_PH_RUN:
      begin
        st_nxt.phase = bbcr_pkg::BBCR_PH_RUN;
      end
      default:
      begin
        st_nxt.phase = bbcr_pkg::BBCR_PH_LOAD;
      end
    endcase

    if (wr)
    begin
      if (reg_addr == `BBCR_OFS_A_CTRL)
      begin
        st_nxt.a_sleep_en = reg_wdata[`BBCR_A_SLEEP_BIT];
      end
      else if (reg_addr == `BBCR_OFS_A_LIMIT)
      begin
        st_nxt.a_ilim = reg_wdata[`BBCR_A_ILIM_HI:`BBCR_A_ILIM_LO];
        st_nxt.a_tmode = reg_wdata[`BBCR_A_TMODE_BIT];
      end
      else if (reg_addr == `BBCR_OFS_B_RUN)
      begin
        st_nxt.b_run = reg_wdata[`BBCR_CODE_HI:`BBCR_CODE_LO];
      end
      else if (reg_addr == `BBCR_OFS_B_STBY)
      begin
        st_nxt.b_stby = reg_wdata[`BBCR_CODE_HI:`BBCR_CODE_LO];
      end
      else if (reg_addr == `BBCR_OFS_B_SLP)
      begin
        st_nxt.b_slp = reg_wdata[`BBCR_CODE_HI:`BBCR_CODE_LO];
      end
      else if (reg_addr == `BBCR_OFS_B_CTRL)
      begin
        st_nxt.b_ctrl = reg_wdata;
      end
    end
    // set from internal logic wins over a host clear in the same cycle
    if (st_r.sync2.a_sleep_set)
    begin
      st_nxt.a_sleep_en = 1'b1;
    end

    st_nxt.rdata = `BBCR_RST_BYTE;
    if (rd)
    begin
      if (reg_addr == `BBCR_OFS_A_CTRL)
      begin
        st_nxt.rdata[`BBCR_A_SLEEP_BIT] = st_r.a_sleep_en;
      end
      else if (reg_addr == `BBCR_OFS_A_LIMIT)
      begin
        st_nxt.rdata[`BBCR_A_ILIM_HI:`BBCR_A_ILIM_LO] = st_r.a_ilim;
        st_nxt.rdata[`BBCR_A_TMODE_BIT] = st_r.a_tmode;
      end
      else if (reg_addr == `BBCR_OFS_B_RUN)
      begin
        st_nxt.rdata[`BBCR_CODE_HI:`BBCR_CODE_LO] = st_r.b_run;
      end
      else if (reg_addr == `BBCR_OFS_B_STBY)
      begin
        st_nxt.rdata[`BBCR_CODE_HI:`BBCR_CODE_LO] = st_r.b_stby;
      end
      else if (reg_addr == `BBCR_OFS_B_SLP)
      begin
        st_nxt.rdata[`BBCR_CODE_HI:`BBCR_CODE_LO] = st_r.b_slp;
      end
      else if (reg_addr == `BBCR_OFS_B_CTRL)
      begin
        st_nxt.rdata = st_r.b_ctrl;
      end
    end

    // outputs to the converters follow the registers one cycle later
    case (st_r.sync2.mode)
      bbcr_pkg::BBCR_MODE_RUN:
      begin
        on = st_r.b_ctrl[`BBCR_B_RUN_EN_BIT];
        st_nxt.drive.b_code = st_r.b_run;
      end
      bbcr_pkg::BBCR_MODE_STANDBY:
      begin
        on = st_r.b_ctrl[`BBCR_B_STBY_EN_BIT];
        st_nxt.drive.b_code = st_r.b_stby;
      end
      bbcr_pkg::BBCR_MODE_SLEEP:
      begin
        on = st_r.b_ctrl[`BBCR_B_SLEEP_EN_BIT];
        st_nxt.drive.b_code = st_r.b_slp;
      end
      default:
      begin
        on = 1'b0;
        st_nxt.drive.b_code = st_r.b_run;
      end
    endcase
    st_nxt.drive.b_on = on;
    st_nxt.drive.b_low_power = on && st_r.b_ctrl[`BBCR_B_LPWR_BIT] &&
      (st_r.sync2.mode == bbcr_pkg::BBCR_MODE_STANDBY ||
       st_r.sync2.mode == bbcr_pkg::BBCR_MODE_SLEEP);
    st_nxt.drive.b_forced_conduction_on_descent =
      st_r.b_ctrl[`BBCR_B_DESC_FORCE_BIT];
    st_nxt.drive.b_forced_conduction = st_r.b_ctrl[`BBCR_B_FORCE_BIT];
    st_nxt.drive.b_discharge_on =
      !on && !st_r.b_ctrl[`BBCR_B_DIS_OFF_BIT];
    st_nxt.drive.a_current_limit = st_r.a_ilim;
    st_nxt.drive.a_timing_scheme = st_r.a_tmode;
    st_nxt.drive.a_sleep_enable = st_r.a_sleep_en;

    // with the fuse select set the slew comes from elsewhere; fast pace here
    slow = st_r.b_ctrl[`BBCR_B_SLEW_BIT] &&
      !st_r.sync2.fuse.scaling_select;
    st_nxt.drive.b_slew_slow = slow;
    limit = slow ? `BBCR_TICK_W'(`BBCR_STEP_SLOW_CYC) :
      `BBCR_TICK_W'(`BBCR_STEP_FAST_CYC);
    st_nxt.drive.b_step_tick = 1'b0;
    if (st_r.tick_cnt >= limit - 9'h001)
    begin
      st_nxt.tick_cnt = 9'h000;
      st_nxt.drive.b_step_tick = 1'b1;
    end
    else
    begin
      st_nxt.tick_cnt = st_r.tick_cnt + 9'h001;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// >>> verif/bbcr_regs_checker.sv
// port assertions for the buck register bank
module bbcr_regs_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic buck_a_sleep_set,
  input wire bbcr_pkg::bbcr_drive_type buck_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] wd1;
  logic [7:0] wd2;
  wire logic mapped = reg_addr inside {8'h35, 8'h36, 8'h38, 8'h39, 8'h3a,
    8'h3b};
  wire logic code_reg = reg_addr inside {8'h38, 8'h39, 8'h3a};
  // drive fields lag a write by two edges, so keep the data that long
  always_ff @(posedge clock)
  begin
    wd1 <= reg_wdata;
    wd2 <= wd1;
  end
  property p_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_unmap; reg_read && !mapped |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_code; reg_read && code_reg |=> reg_rdata[7:6] == 2'h0; endproperty
  a_code: assert property (p_code) else $error("code top bits");
  property p_ilim;
    reg_write && reg_addr == 8'h36 |=> ##1
      buck_drive.a_current_limit == wd2[1:0];
  endproperty
  a_ilim: assert property (p_ilim) else $error("current limit");
  property p_tmode;
    reg_write && reg_addr == 8'h36 |=> ##1
      buck_drive.a_timing_scheme == wd2[4];
  endproperty
  a_tmode: assert property (p_tmode) else $error("timing scheme");
  property p_forced;
    reg_write && reg_addr == 8'h3b |=> ##1 {buck_drive.b_forced_conduction,
      buck_drive.b_forced_conduction_on_descent} == wd2[6:5];
  endproperty
  a_forced: assert property (p_forced) else $error("forced conduction");
  // discharge follows the written bit 7 and the mode enable together
  property p_dis;
    reg_write && reg_addr == 8'h3b |=> ##1
      buck_drive.b_discharge_on == (!buck_drive.b_on && !wd2[7]);
  endproperty
  a_dis: assert property (p_dis) else $error("discharge while on");
  property p_lpwr; buck_drive.b_low_power |-> buck_drive.b_on; endproperty
  a_lpwr: assert property (p_lpwr) else $error("low power while off");
  property p_aset;
    buck_a_sleep_set [*4] |=> buck_drive.a_sleep_enable;
  endproperty
  a_aset: assert property (p_aset) else $error("sleep set lost");
  c_unmap: cover property (reg_read && !mapped);
  c_tick: cover property (buck_drive.b_step_tick);
  c_lpwr: cover property (buck_drive.b_low_power);
endmodule
bind bbcr_regs bbcr_regs_checker u_chk (.clock(clock), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .buck_a_sleep_set(buck_a_sleep_set), .buck_drive(buck_drive));

// >>> verif/bbcr_tb.sv
// self-checking bench for the buck register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  // fuses: limit 10, code 2a, run enable, slow slew, discharge off
  bbcr_pkg::bbcr_fuse_type fuse_in = 12'haae;
  logic [1:0] power_mode = 2'h0;
  logic buck_a_sleep_set = 1'b0;
  bbcr_pkg::bbcr_drive_type buck_drive;
  logic [15:0] mode_exp [4] = '{16'h04d1, 16'h01e2, 16'h06f3, 16'h01d1};
  int mismatches = 0;
  int samples_checked = 0;
  bbcr_regs DUT (.clock(clock), .reset_n(reset_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .fuse_in(fuse_in),
    .power_mode(power_mode), .buck_a_sleep_set(buck_a_sleep_set),
    .buck_drive(buck_drive));
  initial forever #5 clock = ~clock;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask
  // third gap is whole even if the pace changed mid-count
  task automatic pace(input logic [15:0] e);
    int n;
    repeat (3)
    begin
      n = 0;
      do
      begin
        @(posedge clock);
        #1;
        n++;
      end
      while (buck_drive.b_step_tick !== 1'b1 && n < 999);
      if (n == 999)
      begin
        mismatches++;
        tally_and_finish;
      end
    end
    chk("tick gap", e, n[15:0]);
  endtask
  task automatic t_load;
    rd(8'h35, 8'h00);
    rd(8'h36, 8'h02);
    rd(8'h38, 8'h2a);
    rd(8'h39, 8'h2a);
    rd(8'h3a, 8'h2a);
    rd(8'h3b, 8'h93);
  endtask
  task automatic t_fields;
    wr(8'h36, 8'hff);
    rd(8'h36, 8'h13);
    wr(8'h38, 8'hff);
    rd(8'h38, 8'h3f);
    rd(8'h37, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h36, 8'(i));
      settle;
      chk("limit", 16'(i), 16'(buck_drive.a_current_limit));
    end
  endtask
  task automatic t_modes;
    wr(8'h38, 8'h11);
    wr(8'h39, 8'h22);
    wr(8'h3a, 8'h33);
    wr(8'h3b, 8'h6d);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clock);
      power_mode <= 2'(m);
      settle;
      chk("mode drive", mode_exp[m], {5'h00, buck_drive.b_on,
        buck_drive.b_low_power, buck_drive.b_discharge_on,
        buck_drive.b_forced_conduction,
        buck_drive.b_forced_conduction_on_descent,
        buck_drive.b_code});
    end
    @(posedge clock);
    power_mode <= 2'h0;
  endtask
  task automatic t_slew;
    pace(16'h00c8);
    chk("slow pace", 16'h0000, 16'(buck_drive.b_slew_slow));
    wr(8'h3b, 8'h7d);
    pace(16'h0190);
    chk("slow pace", 16'h0001, 16'(buck_drive.b_slew_slow));
    @(posedge clock);
    fuse_in.scaling_select <= 1'b1;
    pace(16'h00c8);
    chk("slow pace", 16'h0000, 16'(buck_drive.b_slew_slow));
  endtask
  task automatic t_sleep_set;
    wr(8'h35, 8'h04);
    rd(8'h35, 8'h04);
    wr(8'h35, 8'h00);
    rd(8'h35, 8'h00);
    @(posedge clock);
    buck_a_sleep_set <= 1'b1;
    settle;
    wr(8'h35, 8'h00);
    rd(8'h35, 8'h04);
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_load;
    t_fields;
    t_modes;
    t_slew;
    t_sleep_set;
    tally_and_finish;
  end
endmodule
